// ==== core/rgctl_pkg.sv ====
// Package holding the regulator control register layout and shared types
package rgctl_pkg;
    // Register placement on the special-function-register bus
    localparam logic [7:0] RGCTL_CTRL_ADDR = 8'hC9;
    localparam logic [7:0] RGCTL_CTRL_PAGE = 8'h00;
    // Field positions
    localparam int RGCTL_OFF_BIT = 7;
    localparam int RGCTL_RSVD_BIT = 6;
    localparam int RGCTL_LEVEL_BIT = 4;
    localparam int RGCTL_DROP_BIT = 0;
    // Reset values of the stored fields and fixed read values
    localparam logic RGCTL_OFF_RST = 1'h0;
    localparam logic RGCTL_LEVEL_RST = 1'h1;
    localparam logic RGCTL_RSVD_READ = 1'h1;
    // Register bus request from the processor core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] page;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } rgctl_bus_type;
    // Controls handed to the analog regulator
    typedef struct packed {
        logic supply_off_bit;
        logic output_level_select;
    } rgctl_analog_type;
endpackage : rgctl_pkg

// ==== core/rgctl_sync.sv ====
// Three-stage synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module rgctl_sync (
    input wire logic clock,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage;       // Stage 0 is read only by stage 1
    logic [2:0] next_stage;
    logic next_sync_out;

    // Shift in, and accept a change only when stages 1 and 2 agree
    always_comb begin
        next_stage = {stage[1:0], async_in};
        next_sync_out = (stage[1] == stage[2]) ? stage[2] : sync_out;
    end

    // Registers only
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stage <= 3'h0;
            sync_out <= 1'h0;
        end else begin
            stage <= next_stage;
            sync_out <= next_sync_out;
        end
    end
endmodule : rgctl_sync
`default_nettype wire

// ==== core/rgctl_top.sv ====
// Regulator control and status register with dropout interrupt request
// What this block does
// [RL1] Bit 7 set disables regulator; resets zero
// [RL2] Bit 4 selects 2.1V or 2.6V; resets one
// [RL3] Bit 6 reads one; software writes one
// [RL4] Bit 5 reads zero, writes ignored
// [RL5] Bits 3 to 1 read zero
// [RL6] Bit 0 is read-only dropout indicator
// [RL7] Dropout raises request only when enabled
// [RL8] No latched pending flag for dropout
// [RL9] Indicator cleared by hardware on recovery
// [RL10] Software disables, polls, then re-enables interrupt
// [RL11] Register decodes at 0xC9, page 0x00
// [RL12] Comparator synchronised; drives indicator and request
`timescale 1ns/10ps
`default_nettype none
module rgctl_top
    import rgctl_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire rgctl_pkg::rgctl_bus_type bus,
    output logic [7:0] rdata,
    input wire logic dropout_raw,
    input wire logic low_input_irq_enable,
    output rgctl_pkg::rgctl_analog_type analog,
    output logic dropout_irq
);
    import rgctl_pkg::*;

    logic dropout_sync;      // Settled comparator level
    logic supply_off_bit;    // Stored disable bit
    logic output_level_select; // Stored level bit
    logic next_supply_off_bit;
    logic next_output_level_select;
    logic [7:0] next_rdata;
    logic hit;               // Access targets this register

    // Address and page decode shared by reads and writes
    function automatic logic decode(input logic [7:0] a, input logic [7:0] p);
        decode = (a == RGCTL_CTRL_ADDR) && (p == RGCTL_CTRL_PAGE); // [RL11]
    endfunction : decode

    // Comparator crosses from the analog side; filtered against glitches
    rgctl_sync u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in(dropout_raw),
        .sync_out(dropout_sync)
    ); // [RL12]

    assign hit = decode(bus.addr, bus.page);

    // Next values of stored bits and read data
    always_comb begin
        next_supply_off_bit = supply_off_bit;
        next_output_level_select = output_level_select;
        next_rdata = 8'h00;
        // Only bits 7 and 4 store; bit 6 write is expected as one but not held
        if (bus.wr && hit) begin
            next_supply_off_bit = bus.wdata[RGCTL_OFF_BIT];        // [RL1]
            next_output_level_select = bus.wdata[RGCTL_LEVEL_BIT]; // [RL2]
        end
        // Read data: unused bits stay zero, reserved bit reads one
        if (bus.rd && hit) begin
            next_rdata[RGCTL_OFF_BIT] = supply_off_bit;
            next_rdata[RGCTL_RSVD_BIT] = RGCTL_RSVD_READ;          // [RL3]
            next_rdata[RGCTL_LEVEL_BIT] = output_level_select;
            next_rdata[RGCTL_DROP_BIT] = dropout_sync;             // [RL6] [RL9] [RL4] [RL5]
        end
    end

    // Registers only
    always_ff @(posedge clock) begin
        if (!nrst) begin
            supply_off_bit <= RGCTL_OFF_RST;                        // [RL1]
            output_level_select <= RGCTL_LEVEL_RST;                 // [RL2]
            rdata <= 8'h00;
        end else begin
            supply_off_bit <= next_supply_off_bit;
            output_level_select <= next_output_level_select;
            rdata <= next_rdata;
        end
    end

    // Analog controls straight from the stored bits
    assign analog.supply_off_bit = supply_off_bit;
    assign analog.output_level_select = output_level_select;

    // Live request, nothing latched, so it drops with the condition
    assign dropout_irq = dropout_sync & low_input_irq_enable;      // [RL7] [RL8] [RL10]

    // Assertions
    write_off_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && hit |=> analog.supply_off_bit == $past(bus.wdata[7])) // [RL1]
        else $error("disable bit not stored");
    write_level_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && hit |=> analog.output_level_select == $past(bus.wdata[4])) // [RL2]
        else $error("level bit not stored");
    other_addr_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.wr && !hit |=> $stable(analog)) // [RL11]
        else $error("foreign write changed register");
    read_fixed_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.rd && hit |=> rdata[6] == 1'b1) // [RL3]
        else $error("reserved bit not one");
    read_unused_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.rd && hit |=> rdata[5] == 1'b0) // [RL4]
        else $error("bit five not zero");
    read_low_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.rd && hit |=> rdata[3:1] == 3'h0) // [RL5]
        else $error("bits three to one not zero");
    read_drop_a: assert property (@(posedge clock) disable iff (!nrst)
        bus.rd && hit |=> rdata[0] == $past(dropout_sync)) // [RL6]
        else $error("indicator mismatch");
    irq_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        dropout_irq == (dropout_sync && low_input_irq_enable)) // [RL7]
        else $error("request gating wrong");
    // A level must be seen on five edges: three stages fill, the filter
    // updates on the fourth, and the settled value is sampled on the fifth
    sequence raw_low_run;
        !dropout_raw [*5];
    endsequence
    sequence raw_high_run;
        dropout_raw [*5];
    endsequence
    irq_drop_a: assert property (@(posedge clock) disable iff (!nrst)
        raw_low_run |-> !dropout_irq) // [RL8]
        else $error("request held after recovery");
    recover_a: assert property (@(posedge clock) disable iff (!nrst)
        raw_low_run |-> !dropout_sync) // [RL9]
        else $error("indicator not cleared");
    sync_rise_a: assert property (@(posedge clock) disable iff (!nrst)
        raw_high_run |-> dropout_sync) // [RL12]
        else $error("synchroniser too slow");
    // Reset must bring the regulator up enabled at the upper level
    reset_value_a: assert property (@(posedge clock) // [RL1]
        !nrst |=> !analog.supply_off_bit && analog.output_level_select)
        else $error("stored bits wrong after reset");
    // Read data is only driven for a read that hits this register
    read_idle_a: assert property (@(posedge clock) disable iff (!nrst)
        !(bus.rd && hit) |=> rdata == 8'h00) // [RL11]
        else $error("read data without a hit");
    // With the enable low no request may leave the block
    irq_masked_a: assert property (@(posedge clock) disable iff (!nrst)
        !low_input_irq_enable |-> !dropout_irq) // [RL7]
        else $error("request while disabled");
endmodule : rgctl_top
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the regulator control register and dropout request
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rgctl_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    rgctl_bus_type bus;
    logic [7:0] rdata;
    logic dropout_raw;
    logic low_input_irq_enable;
    rgctl_analog_type analog;
    logic dropout_irq;
    logic [9:0] notes[$]; // Expected {rdata, analog} per read
    logic pend = 1'b0; // A read was sampled at the last edge
    logic off_m, lvl_m, drop_m; // Reference copy of the register
    logic [7:0] w;
    int n_mismatch = 0;
    int checks_done = 0;
    // Free-running 200 MHz clock
    always #2.5 clock = ~clock;
    rgctl_top rgctl_top_i (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata),
        .dropout_raw(dropout_raw), .low_input_irq_enable(low_input_irq_enable),
        .analog(analog), .dropout_irq(dropout_irq));
    task check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            n_mismatch++;
        end
    endtask : check
    task results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    // Watcher: read data lands one cycle after the request, so compare at the next low phase
    always @(posedge clock) pend <= bus.rd;
    always @(negedge clock) begin
        if (pend && notes.size() > 0) check("read", {rdata, analog}, notes.pop_front());
    end
    task wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(posedge clock);
        bus.addr <= a;
        bus.page <= p;
        bus.wdata <= d;
        bus.wr <= 1'h1;
        @(posedge clock);
        bus.wr <= 1'h0;
        if (a == RGCTL_CTRL_ADDR && p == RGCTL_CTRL_PAGE) begin
            off_m = d[7];
            lvl_m = d[4];
        end
    endtask : wr
    // Reads elsewhere must return zero; analog is noted too so stray writes show up
    task rd(input logic [7:0] a, input logic [7:0] p);
        @(posedge clock);
        bus.addr <= a;
        bus.page <= p;
        bus.rd <= 1'h1;
        if (a == RGCTL_CTRL_ADDR && p == RGCTL_CTRL_PAGE)
            notes.push_back({off_m, 1'h1, 1'h0, lvl_m, 3'h0, drop_m, off_m, lvl_m});
        else notes.push_back({8'h00, off_m, lvl_m});
        @(posedge clock);
        bus.rd <= 1'h0;
    endtask : rd
    // Bounded wait on the request; a miss closes the run
    task wait_irq(input logic v);
        int i;
        for (i = 0; i < 8; i++) begin
            @(negedge clock);
            if (dropout_irq === v) break;
        end
        check("irq", {9'h000, dropout_irq}, {9'h000, v});
        if (i == 8) results();
    endtask : wait_irq
    initial begin
        bus = '0;
        dropout_raw = 1'h0;
        low_input_irq_enable = 1'h0;
        {off_m, lvl_m, drop_m} = 3'h2;
        void'($urandom(32'h8170));
        repeat (12) @(posedge clock);
        nrst <= 1'h1;
        rd(RGCTL_CTRL_ADDR, RGCTL_CTRL_PAGE);
        repeat (8) begin
            w = $urandom | 8'h40;
            wr(RGCTL_CTRL_ADDR, RGCTL_CTRL_PAGE, w);
            rd(RGCTL_CTRL_ADDR, RGCTL_CTRL_PAGE);
        end
        // Neighbouring address and wrong page must be ignored
        wr(8'hC8, RGCTL_CTRL_PAGE, ~{off_m, 3'h0, lvl_m, 3'h0});
        rd(8'hC8, RGCTL_CTRL_PAGE);
        wr(RGCTL_CTRL_ADDR, 8'h01, ~{off_m, 3'h0, lvl_m, 3'h0});
        rd(RGCTL_CTRL_ADDR, 8'h01);
        low_input_irq_enable <= 1'h1;
        dropout_raw <= 1'h1;
        wait_irq(1'h1);
        drop_m = 1'h1;
        wr(RGCTL_CTRL_ADDR, RGCTL_CTRL_PAGE, 8'hC0);
        rd(RGCTL_CTRL_ADDR, RGCTL_CTRL_PAGE);
        dropout_raw <= 1'h0;
        wait_irq(1'h0);
        drop_m = 1'h0;
        rd(RGCTL_CTRL_ADDR, RGCTL_CTRL_PAGE);
        low_input_irq_enable <= 1'h0;
        dropout_raw <= 1'h1;
        repeat (6) @(posedge clock);
        @(negedge clock);
        check("masked", {9'h000, dropout_irq}, 10'h000);
        drop_m = 1'h1;
        rd(RGCTL_CTRL_ADDR, RGCTL_CTRL_PAGE);
        low_input_irq_enable <= 1'h1;
        wait_irq(1'h1);
        @(posedge clock);
        dropout_raw <= 1'h0;
        repeat (6) @(posedge clock);
        nrst <= 1'h0;
        repeat (2) @(posedge clock);
        nrst <= 1'h1;
        {off_m, lvl_m, drop_m} = 3'h2;
        rd(RGCTL_CTRL_ADDR, RGCTL_CTRL_PAGE);
        repeat (2) @(posedge clock);
        results();
    end
endmodule : tb_top
`default_nettype wire
